/* verilog/wdr_cfg.svh */
// Constants of the watchdog and reset-cause block: offsets, bit positions,
// reset values and counts. Included by the package; definitions only.
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

// Register addresses in data space; I/O addresses sit lower by the shift
`define WDR_IO_SHIFT      8'h20
`define WDR_CAUSE_ADDR    8'h54
`define WDR_CTRL_ADDR     8'h60
`define WDR_CAUSE_IO_ADDR (`WDR_CAUSE_ADDR - `WDR_IO_SHIFT)

// Reset-cause bit positions
`define WDR_SCAN_BIT      4
`define WDR_DOG_BIT       3
`define WDR_BOD_BIT       2
`define WDR_PIN_BIT       1
`define WDR_POR_BIT       0

// Watchdog control bit positions
`define WDR_IRQF_BIT      7
`define WDR_IRQE_BIT      6
`define WDR_PS3_BIT       5
`define WDR_UNLK_BIT      4
`define WDR_SRE_BIT       3

// Reset values; power-on marks its own flag
`define WDR_CAUSE_RST     5'h01
`define WDR_CTRL_RST      8'h00

// Unlock window length in system clock cycles
`define WDR_UNLOCK_CYC    3'h4

// Shortest timeout in oscillator ticks, largest legal prescale code
`define WDR_TICK_W        21
`define WDR_BASE_TICKS    21'h000800
`define WDR_MAX_CODE      4'h9

// Fuse level meaning programmed (timer forced on)
`define WDR_FUSE_ON       1'b0

`endif

/* verilog/wdr_pkg.sv */
// Types shared by the watchdog and reset-cause block.
// Assumes wdr_cfg.svh is on the include path.
`include "wdr_cfg.svh"

package wdr_pkg;

  // Operating mode of the timer
  typedef enum logic [1:0] {
    wdr_stop    = 2'b00,
    wdr_irq     = 2'b01,
    wdr_rst     = 2'b10,
    wdr_irq_rst = 2'b11
  } wdr_mode_t;

  // Whole state of the top module
  typedef struct packed {
    logic [4:0]             cause;
    logic                   irq_flag;
    logic                   irq_en;
    logic                   system_reset_enable;
    logic [3:0]             presc;
    logic [2:0]             unlock_cnt;
    logic [`WDR_TICK_W-1:0] ticks;
    logic                   osc_prev;
    logic [7:0]             rdata;
    logic                   irq_req;
    logic                   dog_rst;
  } wdr_state_t;

  // State of the two-stage synchroniser
  typedef struct packed {
    logic meta;
    logic sync;
  } wdr_sync_t;

endpackage

/* verilog/wdr_sync.sv */
// Two-stage level synchroniser for the watchdog oscillator.
// Assumes the input is unrelated to clk; the first stage feeds only the
// second.
`timescale 1ns/1ps

module wdr_sync
  import wdr_pkg::*;
(
  // Clock, reset and enable
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Level in and synchronised level out
  input  wire logic d,
  output logic      q
);

  wdr_sync_t s_reg;
  wdr_sync_t s_next;

  // Shift the level through both stages
  always_comb begin
    s_next      = s_reg;
    s_next.meta = d;
    s_next.sync = s_reg.meta;
  end

  // Register the stages; ce freezes them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{meta: 1'b0, sync: 1'b0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.sync;

endmodule // wdr_sync

/* verilog/wdr_top.sv */
// Watchdog timer with reset-cause flags, reached through the processor's
// I/O and data space. Assumes single-cycle register strobes synchronous
// to clk, a free-running slow oscillator level on wdt_osc, and that
// arst_n is the power-on reset.
`timescale 1ns/1ps

// Functional notes
// RQ1 - Reset-cause register answers at data offset and at I/O offset 0x20 lower.
// RQ2 - Scan reset sets bit 4; power-on or written zero clears it.
// RQ3 - Watchdog reset sets bit 3; power-on or written zero clears it.
// RQ4 - Brown-out reset sets bit 2; power-on or written zero clears it.
// RQ5 - Pin reset sets bit 1; power-on or written zero clears it.
// RQ6 - Power-on sets bit 0; only a written zero clears it.
// RQ7 - Software should read then clear reset causes early after start-up.
// RQ8 - Timeout in interrupt mode sets bit 7; vector or written one clears.
// RQ9 - Interrupt request needs global enable and timeout interrupt enable.
// RQ10 - Fuse off: enables pick stopped, interrupt, reset or combined mode.
// RQ11 - Programmed fuse forces reset mode whatever the enables hold.
// RQ12 - Combined mode: vector clears enable and flag, leaving reset mode.
// RQ13 - Combined mode: unserviced flag at next timeout gives system reset.
// RQ14 - Software re-arms interrupt enable after each watchdog interrupt.
// RQ15 - Clearing reset enable or prescale needs unlock; unlock ends after four.
// RQ16 - Watchdog reset flag forces reset enable set until it is cleared.
// RQ17 - Prescale bits 5 and 2:0; code n gives 2048 shl n ticks.
// RQ18 - Unlock write sets unlock and enable, new values within four cycles.
// RQ19 - Counter counts slow oscillator ticks, independent of system clock; here ticks are sampled on clk and lost while ce is low.
// RQ20 - Restart strobe returns the tick count to zero.
// RQ21 - Reset-mode timeout gives a one-cycle system reset pulse.
// RQ22 - Reset-cause bits 7:5 read zero and ignore writes.
// RQ23 - Slow oscillator is synchronised before it drives flags or reset.
module wdr_top
  import wdr_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Register access
  input  wire logic [7:0] bus_addr,
  input  wire logic       io_sel,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // Processor handshakes
  input  wire logic       global_ie,
  input  wire logic       irq_ack,
  input  wire logic       wdr_restart,
  output logic            irq_req,
  // Reset sources and the watchdog reset pulse
  input  wire logic       sys_rst,
  input  wire logic       ext_rst_evt,
  input  wire logic       bod_rst_evt,
  input  wire logic       scan_rst_evt,
  output logic            dog_reset,
  // Slow oscillator and fuse
  input  wire logic       wdt_osc,
  input  wire logic       force_on_fuse
);

  wdr_state_t             s_reg;
  wdr_state_t             s_next;
  logic                   osc_sync;
  logic                   osc_tick;
  logic [7:0]             eff_addr;
  logic                   fuse_on;
  logic                   wde_eff;
  logic                   unlocked;
  wdr_mode_t              mode;
  logic [3:0]             code;
  logic [`WDR_TICK_W-1:0] limit;
  logic [`WDR_TICK_W-1:0] ticks_inc;
  logic                   timeout;
  logic                   fire_rst;
  logic [7:0]             ctrl_view;

  //--------------------------------------------------------------------
  // Oscillator crossing
  //--------------------------------------------------------------------

  // Only the second stage is looked at; rising edges become ticks
  wdr_sync u_osc_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      (wdt_osc),
    .q      (osc_sync)
  );
  assign osc_tick = osc_sync & ~s_reg.osc_prev; // RQ19 RQ23

  //--------------------------------------------------------------------
  // Decoded views
  //--------------------------------------------------------------------

  // I/O instructions address the same register 0x20 lower
  assign eff_addr = io_sel ? (bus_addr + `WDR_IO_SHIFT) : bus_addr; // RQ1
  assign fuse_on  = (force_on_fuse == `WDR_FUSE_ON);
  // Watchdog reset flag holds the reset enable on
  assign wde_eff  = s_reg.system_reset_enable | s_reg.cause[`WDR_DOG_BIT] | fuse_on; // RQ16
  assign unlocked = (s_reg.unlock_cnt != 3'h0);
  // Fuse locks the timer into reset mode
  assign mode = fuse_on ? wdr_rst
                        : wdr_mode_t'({wde_eff, s_reg.irq_en}); // RQ10 RQ11
  // Reserved codes fall back to the longest timeout
  assign code  = (s_reg.presc > `WDR_MAX_CODE) ? `WDR_MAX_CODE : s_reg.presc;
  assign limit = `WDR_BASE_TICKS << code; // RQ17
  assign ticks_inc = s_reg.ticks + `WDR_TICK_W'(1);

  // Control register as software sees it
  assign ctrl_view = {s_reg.irq_flag, s_reg.irq_en & ~fuse_on,
                      s_reg.presc[3], unlocked, wde_eff,
                      s_reg.presc[2:0]};

  //--------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------

  // Hardware sets are applied after software clears so that they win
  always_comb begin
    s_next         = s_reg;
    s_next.dog_rst = 1'b0;
    timeout        = 1'b0;
    fire_rst       = 1'b0;
    if (sys_rst) begin
      // Any system reset returns control and the interrupt flag to defaults, reset-cause flags survive
      s_next.irq_flag   = 1'b0;
      s_next.irq_en     = 1'b0;
      s_next.system_reset_enable        = 1'b0;
      s_next.presc      = 4'h0;
      s_next.unlock_cnt = 3'h0;
      s_next.ticks      = '0;
    end else begin
      if (unlocked) begin
        s_next.unlock_cnt = s_reg.unlock_cnt - 3'h1; // RQ15
      end
      // Writes to the reset-cause register only clear
      if (wr_en && eff_addr == `WDR_CAUSE_ADDR) begin
        s_next.cause = s_reg.cause & wr_data[4:0]; // RQ6 RQ22
      end
      // Control register writes; clearing reset enable and changing prescale are guarded by the unlock window
      if (wr_en && eff_addr == `WDR_CTRL_ADDR) begin
        if (wr_data[`WDR_IRQF_BIT]) begin
          s_next.irq_flag = 1'b0; // RQ8
        end
        s_next.irq_en = wr_data[`WDR_IRQE_BIT];
        if (wr_data[`WDR_SRE_BIT]) begin
          s_next.system_reset_enable = 1'b1;
        end else if (unlocked && !s_reg.cause[`WDR_DOG_BIT]) begin
          s_next.system_reset_enable = 1'b0; // RQ15 RQ16
        end
        if (unlocked) begin
          s_next.presc = {wr_data[`WDR_PS3_BIT], wr_data[2:0]}; // RQ15
        end
        if (wr_data[`WDR_UNLK_BIT] && wr_data[`WDR_SRE_BIT]) begin
          s_next.unlock_cnt = `WDR_UNLOCK_CYC; // RQ18
        end
      end
      // Vector taken: flag cleared, combined mode drops to reset mode
      if (irq_ack) begin
        s_next.irq_flag = 1'b0; // RQ8
        if (mode == wdr_irq_rst) begin
          s_next.irq_en = 1'b0; // RQ12
        end
      end
      // Tick counter; stopped or restarted means back to zero
      if (mode == wdr_stop || wdr_restart) begin
        s_next.ticks = '0; // RQ20
      end else if (osc_tick) begin
        if (ticks_inc >= limit) begin
          timeout      = 1'b1; // RQ17
          s_next.ticks = '0;
        end else begin
          s_next.ticks = ticks_inc;
        end
      end
      // Timeout action per mode
      if (timeout) begin
        case (mode)
          wdr_irq: begin
            s_next.irq_flag = 1'b1; // RQ8
          end
          wdr_rst: begin
            fire_rst = 1'b1;
          end
          wdr_irq_rst: begin
            if (s_reg.irq_flag) begin
              fire_rst = 1'b1; // RQ13
            end else begin
              s_next.irq_flag = 1'b1; // RQ12
            end
          end
          default: begin
            fire_rst = 1'b0;
          end
        endcase
      end
    end
    // Reset pulse and its cause flag
    if (fire_rst) begin
      s_next.dog_rst                  = 1'b1; // RQ21
      s_next.cause[`WDR_DOG_BIT]      = 1'b1; // RQ3
    end
    // External causes set their flags over any same-cycle clear
    if (scan_rst_evt) begin
      s_next.cause[`WDR_SCAN_BIT] = 1'b1; // RQ2
    end
    if (bod_rst_evt) begin
      s_next.cause[`WDR_BOD_BIT] = 1'b1; // RQ4
    end
    if (ext_rst_evt) begin
      s_next.cause[`WDR_PIN_BIT] = 1'b1; // RQ5
    end
    s_next.osc_prev = osc_sync;
    // Read data registered, unmapped addresses give zero
    if (rd_en) begin
      if (eff_addr == `WDR_CAUSE_ADDR) begin
        s_next.rdata = {3'h0, s_reg.cause}; // RQ1 RQ22
      end else if (eff_addr == `WDR_CTRL_ADDR) begin
        s_next.rdata = ctrl_view;
      end else begin
        s_next.rdata = 8'h00;
      end
    end
    // Request only while both enables are set
    s_next.irq_req = s_next.irq_flag & s_next.irq_en & ~fuse_on
                     & global_ie; // RQ9
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------

  // Power-on leaves only its own flag; ce freezes everything
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{cause: `WDR_CAUSE_RST, default: '0}; // RQ6
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign rd_data   = s_reg.rdata;
  assign irq_req   = s_reg.irq_req;
  assign dog_reset = s_reg.dog_rst;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------

  io_cause_read_a: assert property ( // RQ1
    @(posedge clk) disable iff (!arst_n)
    (ce && rd_en && io_sel && bus_addr == `WDR_CAUSE_IO_ADDR)
    |=> (rd_data == {3'h0, $past(s_reg.cause)}))
    else $error("reset cause not readable at io offset");

  scan_flag_set_a: assert property ( // RQ2
    @(posedge clk) disable iff (!arst_n)
    (ce && scan_rst_evt) |=> s_reg.cause[`WDR_SCAN_BIT])
    else $error("scan reset flag not set");

  dog_flag_set_a: assert property ( // RQ3
    @(posedge clk) disable iff (!arst_n)
    dog_reset |-> s_reg.cause[`WDR_DOG_BIT])
    else $error("watchdog reset without its flag");

  reset_pulse_len_a: assert property ( // RQ21
    @(posedge clk) disable iff (!arst_n)
    (dog_reset && ce) |=> !dog_reset)
    else $error("watchdog reset pulse longer than one cycle");

  irq_gate_a: assert property ( // RQ9
    @(posedge clk) disable iff (!arst_n)
    (ce && (!global_ie || !s_next.irq_en)) |=> !irq_req)
    else $error("interrupt request without both enables");

  unlock_expiry_a: assert property ( // RQ15
    @(posedge clk) disable iff (!arst_n)
    (ce && !sys_rst && wr_en && eff_addr == `WDR_CTRL_ADDR
     && wr_data[`WDR_UNLK_BIT] && wr_data[`WDR_SRE_BIT])
    ##1 (ce && !sys_rst && !wr_en)[*4] |=> !unlocked)
    else $error("unlock window not closed after four cycles");

  dog_flag_holds_a: assert property ( // RQ16
    @(posedge clk) disable iff (!arst_n)
    (ce && rd_en && eff_addr == `WDR_CTRL_ADDR
     && s_reg.cause[`WDR_DOG_BIT]) |=> rd_data[`WDR_SRE_BIT])
    else $error("reset enable reads clear while dog flag set");

  fuse_forces_a: assert property ( // RQ11
    @(posedge clk) disable iff (!arst_n)
    fuse_on |-> (mode == wdr_rst))
    else $error("programmed fuse did not force reset mode");

  ack_clears_en_a: assert property ( // RQ12
    @(posedge clk) disable iff (!arst_n)
    (ce && !sys_rst && irq_ack && !wr_en && mode == wdr_irq_rst)
    |=> !s_reg.irq_en)
    else $error("vector did not clear interrupt enable");

  second_timeout_a: assert property ( // RQ13
    @(posedge clk) disable iff (!arst_n)
    (ce && !sys_rst && timeout && mode == wdr_irq_rst && s_reg.irq_flag)
    |=> dog_reset)
    else $error("unserviced combined timeout gave no reset");

endmodule // wdr_top

/* bench/wdr_top_bench.sv */
// Self-checking bench for the watchdog and reset-cause block.
// Assumes the design package and modules under verilog/ compile first.
`timescale 1ns/1ps

module wdr_top_bench
  import wdr_pkg::*;
;
  // ----------------------------------------
  // Stimulus, observation and bookkeeping
  // ----------------------------------------
  logic       clk           = 1'b0;
  logic       arst_n        = 1'b0;
  logic       ce            = 1'b1;
  logic [7:0] bus_addr      = 8'h00;
  logic       io_sel        = 1'b0;
  logic       wr_en         = 1'b0;
  logic       rd_en         = 1'b0;
  logic [7:0] wr_data       = 8'h00;
  logic [7:0] rd_data;
  logic       global_ie     = 1'b0;
  logic       irq_ack       = 1'b0;
  logic       wdr_restart   = 1'b0;
  logic       irq_req;
  logic       sys_rst       = 1'b0;
  logic       ext_rst_evt   = 1'b0;
  logic       bod_rst_evt   = 1'b0;
  logic       scan_rst_evt  = 1'b0;
  logic       dog_reset;
  logic       wdt_osc       = 1'b0;
  logic       force_on_fuse = 1'b1;
  logic       rd_took       = 1'b0;
  logic [8:0] notes[$];
  logic [7:0] rnd           = 8'h5f;
  logic [7:0] exp_c;
  int         failures        = 0;
  int         samples_checked = 0;
  int         cycles          = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  wdr_top i_dut (
    .clk, .arst_n, .ce, .bus_addr, .io_sel, .wr_en, .rd_en, .wr_data,
    .rd_data, .global_ie, .irq_ack, .wdr_restart, .irq_req, .sys_rst,
    .ext_rst_evt, .bod_rst_evt, .scan_rst_evt, .dog_reset, .wdt_osc,
    .force_on_fuse
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(logic [8:0] seen, logic [8:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic io, logic [7:0] d);
    @(negedge clk);
    {bus_addr, io_sel, wr_data, wr_en} = {a, io, d, 1'b1};
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  // Note goes in before the strobe, so the watcher always finds it
  task automatic rd(logic [7:0] a, logic io, logic [7:0] e);
    notes.push_back({1'b0, e});
    @(negedge clk);
    {bus_addr, io_sel, rd_en} = {a, io, 1'b1};
    @(negedge clk);
    rd_en = 1'b0;
  endtask

  // Oscillator ticks two cycles high, two low; tail covers sync latency
  task automatic ticks(int n);
    repeat (n) begin
      @(negedge clk);
      wdt_osc = 1'b1;
      cyc(2);
      wdt_osc = 1'b0;
      cyc(1);
    end
    cyc(8);
  endtask

  // ----------------------------------------
  // Watcher and hang guard
  // ----------------------------------------
  always @(posedge clk)
    rd_took <= rd_en & ce;

  // An unannounced result meets 1ff, which no real result matches
  always @(negedge clk) begin
    if (rd_took)
      check({1'b0, rd_data}, notes.size() ? notes.pop_front() : 9'h1ff);
    if (dog_reset === 1'b1)
      check(9'h101, notes.size() ? notes.pop_front() : 9'h1ff);
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 75000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(12);
    arst_n = 1'b1;
    // Reset-cause register, both address spaces, an unmapped place
    rd(8'h54, 1'b0, 8'h01);
    rd(8'h34, 1'b1, 8'h01);
    rd(8'h60, 1'b0, 8'h00);
    wr(8'h55, 1'b0, 8'hff);
    rd(8'h55, 1'b0, 8'h00);
    pulse(ext_rst_evt);
    pulse(bod_rst_evt);
    pulse(scan_rst_evt);
    pulse(sys_rst);
    rd(8'h54, 1'b0, 8'h17);
    wr(8'h54, 1'b0, 8'hff);
    rd(8'h34, 1'b1, 8'h17);
    exp_c = 8'h17;
    // Random events and writes: a zero clears, a one leaves alone
    repeat (6) begin
      rnd = lfsr(rnd);
      @(negedge clk);
      {scan_rst_evt, bod_rst_evt, ext_rst_evt} = {rnd[4], rnd[2], rnd[1]};
      @(negedge clk);
      {scan_rst_evt, bod_rst_evt, ext_rst_evt} = 3'b000;
      exp_c = exp_c | (rnd & 8'h16);
      rnd = lfsr(rnd);
      wr(rnd[7] ? 8'h34 : 8'h54, rnd[7], rnd);
      exp_c = exp_c & rnd;
      rd(8'h54, 1'b0, exp_c);
    end
    wr(8'h54, 1'b0, 8'h00);
    rd(8'h54, 1'b0, 8'h00);
    $display("test reset cause done");

    // Timed unlock: locked, open, expired, reopened
    wr(8'h60, 1'b0, 8'h27);
    rd(8'h60, 1'b0, 8'h00);
    wr(8'h60, 1'b0, 8'h18);
    rd(8'h60, 1'b0, 8'h18);
    wr(8'h60, 1'b0, 8'h27);
    rd(8'h60, 1'b0, 8'h27);
    wr(8'h60, 1'b0, 8'h3f);
    cyc(5);
    wr(8'h60, 1'b0, 8'h00);
    rd(8'h60, 1'b0, 8'h2f);
    wr(8'h60, 1'b0, 8'h3f);
    wr(8'h60, 1'b0, 8'h00);
    // Read lands on the last open edge, so unlock still shows
    rd(8'h60, 1'b0, 8'h10);
    $display("test unlock done");

    // Interrupt mode: exact count, global gate, vector clear
    global_ie = 1'b1;
    wr(8'h60, 1'b0, 8'h40);
    ticks(2047);
    check({8'h00, irq_req}, 9'h000);
    // Frozen clock enable: the tick in this gap is never seen
    ce = 1'b0;
    ticks(1);
    ce = 1'b1;
    check({8'h00, irq_req}, 9'h000);
    ticks(1);
    check({8'h00, irq_req}, 9'h001);
    rd(8'h60, 1'b0, 8'hc0);
    global_ie = 1'b0;
    cyc(3);
    check({8'h00, irq_req}, 9'h000);
    global_ie = 1'b1;
    pulse(irq_ack);
    rd(8'h60, 1'b0, 8'h40);
    wr(8'h60, 1'b0, 8'h00);
    $display("test interrupt mode done");

    // Reset mode with a restart part way through
    wr(8'h60, 1'b0, 8'h08);
    ticks(1000);
    pulse(wdr_restart);
    ticks(2047);
    notes.push_back(9'h101);
    ticks(1);
    pulse(sys_rst);
    rd(8'h54, 1'b0, 8'h08);
    wr(8'h54, 1'b0, 8'h00);
    wr(8'h60, 1'b0, 8'h18);
    wr(8'h60, 1'b0, 8'h00);
    rd(8'h60, 1'b0, 8'h10);
    $display("test reset mode done");

    // Combined mode: vector, re-arm, then an unserviced timeout
    wr(8'h60, 1'b0, 8'h48);
    ticks(2048);
    check({8'h00, irq_req}, 9'h001);
    rd(8'h60, 1'b0, 8'hc8);
    pulse(irq_ack);
    rd(8'h60, 1'b0, 8'h08);
    wr(8'h60, 1'b0, 8'h48);
    ticks(2048);
    rd(8'h60, 1'b0, 8'hc8);
    notes.push_back(9'h101);
    ticks(2048);
    pulse(sys_rst);
    rd(8'h60, 1'b0, 8'h08);
    wr(8'h60, 1'b0, 8'h18);
    wr(8'h60, 1'b0, 8'h00);
    rd(8'h60, 1'b0, 8'h18);
    wr(8'h54, 1'b0, 8'h00);
    wr(8'h60, 1'b0, 8'h18);
    wr(8'h60, 1'b0, 8'h00);
    rd(8'h60, 1'b0, 8'h10);
    $display("test combined mode done");

    // Fuse programmed: reset mode whatever the enables hold
    force_on_fuse = 1'b0;
    rd(8'h60, 1'b0, 8'h08);
    wr(8'h60, 1'b0, 8'h40);
    rd(8'h60, 1'b0, 8'h08);
    notes.push_back(9'h101);
    ticks(2048);
    check({8'h00, irq_req}, 9'h000);
    check({8'h00, notes.size() == 0}, 9'h001);
    $display("test fuse done");
    tally_and_finish();
  end
endmodule // wdr_top_bench
